/* core/ltcomp_pkg.sv */
// package of constants and carrier types for the temperature compensation datapath
package ltcomp_pkg;
  localparam int TEMP_W = 10;          // temperature width, 0.5 K per lsb
  localparam int COEF_W = 8;           // signed coefficient width
  localparam int CODE_W = 10;          // nominal and compensated code width
  localparam int DT_W = TEMP_W + 1;    // signed temperature deviation
  localparam int SHIFT_Q = 18;         // weight of the second-order term
  localparam int SHIFT_L = 13;         // weight of the first-order term
  localparam int NUM_CH = 3;           // bias, modulation, photodiode
  localparam logic [CODE_W-1:0] CODE_RST = 10'h000;
  localparam logic [1:0] CH_BIAS = 2'h0;
  localparam logic [1:0] CH_MOD = 2'h1;
  localparam logic [1:0] CH_PD = 2'h2;

  // one coefficient pair
  typedef struct packed {
    logic signed [COEF_W-1:0] first_order_coef;
    logic signed [COEF_W-1:0] second_order_coef;
  } ltcomp_coef_t;

  // settings shared by the three channels, plus the apc enable that no channel uses
  typedef struct packed {
    logic ext_temp_en;
    logic apc_en;
    logic [TEMP_W-1:0] t_nom;
    logic [TEMP_W-1:0] t_ext;
  } ltcomp_sys_t;
endpackage

/* core/ltcomp_scale.sv */
// one channel of quadratic scaling with saturation
`timescale 1ns/100ps
`default_nettype none
module ltcomp_scale
  import ltcomp_pkg::*;
#(
  parameter int CW = CODE_W
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic [CW-1:0] nom_code,
  input wire ltcomp_pkg::ltcomp_coef_t coef,
  input wire logic signed [DT_W-1:0] delta_t,
  output logic [CW-1:0] comp_code_r
);
  // full-precision terms; sum scaled by 2^18 so both weights stay exact
  localparam int PW = 48;
  logic signed [PW-1:0] dt_sq;
  logic signed [PW-1:0] factor;
  logic signed [PW-1:0] prod;
  logic signed [PW-1:0] res;
  logic [CW-1:0] comp_nxt;

  // factor = second*dt^2 + first*dt*2^5 + 2^18, then nominal times factor >> 18
  always_comb begin
    dt_sq = PW'(delta_t) * PW'(delta_t);
    factor = PW'(coef.second_order_coef) * dt_sq // [RULE1] [RULE6]
           + ((PW'(coef.first_order_coef) * PW'(delta_t)) <<< (SHIFT_Q - SHIFT_L))
           + (PW'(1) <<< SHIFT_Q);
    prod = $signed({{(PW-CW){1'b0}}, nom_code}) * factor; // [RULE8] code scaled directly
    res = prod >>> SHIFT_Q;
    if (res < 0) begin
      comp_nxt = '0; // [RULE10] clamp low
    end else if (res > $signed(PW'({CW{1'b1}}))) begin
      comp_nxt = {CW{1'b1}}; // [RULE10] clamp high
    end else begin
      comp_nxt = res[CW-1:0];
    end
  end

  // result register
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      comp_code_r <= CW'(CODE_RST);
    end else begin
      comp_code_r <= comp_nxt;
    end
  end

  a_zero_coef_pass: assert property (@(posedge sys_clk) disable iff (!arst_n) // [RULE1]
    (coef == '0) |=> (comp_code_r == $past(nom_code)))
    else $error("zero coefficients must pass nominal code");
  a_zero_dt_pass: assert property (@(posedge sys_clk) disable iff (!arst_n) // [RULE1]
    (delta_t == '0) |=> (comp_code_r == $past(nom_code)))
    else $error("zero deviation must pass nominal code");
  a_zero_nom_zero: assert property (@(posedge sys_clk) disable iff (!arst_n) // [RULE10]
    (nom_code == '0) |=> (comp_code_r == '0))
    else $error("zero nominal code must give zero");
endmodule
`default_nettype wire

/* core/ltcomp_top.sv */
// temperature compensation datapath for bias, modulation and photodiode codes
// Functional notes
// RULE1 - result is nominal times (second*2^-18*dT^2 + first*2^-13*dT + 1)
// RULE2 - same calculation applied to bias, modulation and photodiode codes
// RULE3 - select low: deviation is die temperature minus reference
// RULE4 - select high: deviation is host temperature minus reference
// RULE5 - all temperatures are unsigned 10-bit at half kelvin per lsb
// RULE6 - coefficients are 8-bit two's complement, -128 to +127
// RULE7 - each quantity has its own coefficient pair
// RULE8 - scaling acts on digital codes; photodiode log code scaled directly
// RULE9 - one settings bit enables automatic power control for the bias loop
// RULE10 - deviation is signed, one bit wider; results saturate
`timescale 1ns/100ps
`default_nettype none
module ltcomp_top
  import ltcomp_pkg::*;
#(
  parameter int CW = CODE_W
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire ltcomp_pkg::ltcomp_sys_t system_settings,
  input wire logic [TEMP_W-1:0] t_die_adc,
  input wire logic [CW-1:0] bias_nom_code,
  input wire logic [CW-1:0] mod_nom_code,
  input wire logic [CW-1:0] pd_nom_code,
  input wire ltcomp_pkg::ltcomp_coef_t bias_coef,
  input wire ltcomp_pkg::ltcomp_coef_t mod_coef,
  input wire ltcomp_pkg::ltcomp_coef_t pd_coef,
  output logic [CW-1:0] bias_comp_r,
  output logic [CW-1:0] mod_comp_r,
  output logic [CW-1:0] pd_comp_r,
  output logic apc_en_r,
  output logic signed [DT_W-1:0] delta_t_r
);
  logic signed [DT_W-1:0] delta_t_nxt;
  logic [TEMP_W-1:0] t_sel;
  logic chk_armed_r;

  // signed deviation from the reference; the extra bit holds -1023..1023 without wrapping
  function automatic logic signed [DT_W-1:0] temp_dev(
    input logic [TEMP_W-1:0] t_meas,
    input logic [TEMP_W-1:0] t_ref
  );
    return $signed({1'b0, t_meas}) - $signed({1'b0, t_ref}); // [RULE5] [RULE10]
  endfunction

  // true when neither coefficient of a pair is negative
  function automatic logic pair_nonneg(
    input ltcomp_coef_t c
  );
    return !c.first_order_coef[COEF_W-1] && !c.second_order_coef[COEF_W-1]; // [RULE6]
  endfunction

  // true when neither coefficient of a pair is positive
  function automatic logic pair_nonpos(
    input ltcomp_coef_t c
  );
    return (c.first_order_coef[COEF_W-1] || (c.first_order_coef == '0)) // [RULE6]
      && (c.second_order_coef[COEF_W-1] || (c.second_order_coef == '0));
  endfunction

  // pick temperature source and form signed deviation
  always_comb begin
    t_sel = system_settings.ext_temp_en ? system_settings.t_ext : t_die_adc; // [RULE3] [RULE4] [RULE5]
    delta_t_nxt = temp_dev(t_sel, system_settings.t_nom); // [RULE10]
  end

  // timing: deviation and apc copy register one edge after their inputs; channel codes
  // register one edge after nominal code and coefficients, so a temperature step reaches
  // them two edges later; every edge takes fresh inputs, nothing is held in between
  // deviation register feeds all three channels
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      delta_t_r <= '0;
    end else begin
      delta_t_r <= delta_t_nxt;
    end
  end

  // automatic power control enable
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      apc_en_r <= 1'b0;
    end else begin
      apc_en_r <= system_settings.apc_en; // [RULE9]
    end
  end

  // three identical channels, each with its own pair
  ltcomp_scale #(.CW(CW)) u_bias ( // [RULE2] [RULE7]
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .nom_code(bias_nom_code),
    .coef(bias_coef),
    .delta_t(delta_t_r),
    .comp_code_r(bias_comp_r)
  );
  ltcomp_scale #(.CW(CW)) u_mod ( // [RULE2] [RULE7]
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .nom_code(mod_nom_code),
    .coef(mod_coef),
    .delta_t(delta_t_r),
    .comp_code_r(mod_comp_r)
  );
  ltcomp_scale #(.CW(CW)) u_pd ( // [RULE2] [RULE7] [RULE8]
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .nom_code(pd_nom_code),
    .coef(pd_coef),
    .delta_t(delta_t_r),
    .comp_code_r(pd_comp_r)
  );

  // arms the hold checks from the second edge after reset, once every register holds a computed value
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      chk_armed_r <= 1'b0;
    end else begin
      chk_armed_r <= 1'b1;
    end
  end

  // deviation follows the selected source
  a_dt_internal: assert property (@(posedge sys_clk) disable iff (!arst_n) // [RULE3]
    !system_settings.ext_temp_en
    |=> delta_t_r == temp_dev($past(t_die_adc), $past(system_settings.t_nom)))
    else $error("internal deviation wrong");
  a_dt_external: assert property (@(posedge sys_clk) disable iff (!arst_n) // [RULE4]
    system_settings.ext_temp_en
    |=> delta_t_r == temp_dev($past(system_settings.t_ext), $past(system_settings.t_nom)))
    else $error("external deviation wrong");
  a_dt_range: assert property (@(posedge sys_clk) disable iff (!arst_n) // [RULE5] [RULE10]
    (delta_t_r <= 11'sh3FF) && (delta_t_r >= -11'sh3FF))
    else $error("deviation out of range");
  a_dt_no_wrap: assert property (@(posedge sys_clk) disable iff (!arst_n) // [RULE10]
    1'b1
    |=> (delta_t_r < 0) == ($past(t_sel) < $past(system_settings.t_nom)))
    else $error("deviation sign wrapped");

  // the unselected source must not reach the deviation
  a_dt_die_only: assert property (@(posedge sys_clk) disable iff (!arst_n) // [RULE3]
    chk_armed_r && !system_settings.ext_temp_en && $stable(system_settings.ext_temp_en)
      && $stable(t_die_adc) && $stable(system_settings.t_nom)
    |=> $stable(delta_t_r))
    else $error("host temperature reached internal deviation");
  a_dt_host_only: assert property (@(posedge sys_clk) disable iff (!arst_n) // [RULE4]
    chk_armed_r && system_settings.ext_temp_en && $stable(system_settings.ext_temp_en)
      && $stable(system_settings.t_ext) && $stable(system_settings.t_nom)
    |=> $stable(delta_t_r))
    else $error("die temperature reached external deviation");

  // apc copy follows its setting only
  a_apc_follow: assert property (@(posedge sys_clk) disable iff (!arst_n) // [RULE9]
    ##1 apc_en_r == $past(system_settings.apc_en))
    else $error("apc enable not following setting");
  a_apc_hold: assert property (@(posedge sys_clk) disable iff (!arst_n) // [RULE9]
    chk_armed_r && $stable(system_settings.apc_en)
    |=> $stable(apc_en_r))
    else $error("apc enable moved without its setting");

  // identical inputs give identical codes on every channel
  a_equal_channels: assert property (@(posedge sys_clk) disable iff (!arst_n) // [RULE2] [RULE7]
    (bias_nom_code == mod_nom_code && bias_coef == mod_coef)
    |=> (bias_comp_r == mod_comp_r))
    else $error("identical channels differ");
  a_mod_pd_equal: assert property (@(posedge sys_clk) disable iff (!arst_n) // [RULE2] [RULE8]
    (mod_nom_code == pd_nom_code && mod_coef == pd_coef)
    |=> (mod_comp_r == pd_comp_r))
    else $error("photodiode channel differs from modulation");

  // each code moves only when its own inputs or the deviation move
  a_bias_hold: assert property (@(posedge sys_clk) disable iff (!arst_n) // [RULE7]
    chk_armed_r && $stable(bias_nom_code) && $stable(bias_coef)
      && $stable(delta_t_r)
    |=> $stable(bias_comp_r))
    else $error("bias code moved without cause");
  a_mod_hold: assert property (@(posedge sys_clk) disable iff (!arst_n) // [RULE7]
    chk_armed_r && $stable(mod_nom_code) && $stable(mod_coef)
      && $stable(delta_t_r)
    |=> $stable(mod_comp_r))
    else $error("modulation code moved without cause");
  a_pd_hold: assert property (@(posedge sys_clk) disable iff (!arst_n) // [RULE7]
    chk_armed_r && $stable(pd_nom_code) && $stable(pd_coef)
      && $stable(delta_t_r)
    |=> $stable(pd_comp_r))
    else $error("photodiode code moved without cause");

  // non-negative pairs above the reference never lower a code, non-positive ones never raise it
  a_bias_grow: assert property (@(posedge sys_clk) disable iff (!arst_n) // [RULE1] [RULE6]
    pair_nonneg(bias_coef) && (delta_t_r >= 0)
    |=> bias_comp_r >= $past(bias_nom_code))
    else $error("bias code fell under non-negative coefficients");
  a_bias_shrink: assert property (@(posedge sys_clk) disable iff (!arst_n) // [RULE1] [RULE6]
    pair_nonpos(bias_coef) && (delta_t_r >= 0)
    |=> bias_comp_r <= $past(bias_nom_code))
    else $error("bias code rose under non-positive coefficients");
  a_mod_grow: assert property (@(posedge sys_clk) disable iff (!arst_n) // [RULE1] [RULE6]
    pair_nonneg(mod_coef) && (delta_t_r >= 0)
    |=> mod_comp_r >= $past(mod_nom_code))
    else $error("modulation code fell under non-negative coefficients");
  a_mod_shrink: assert property (@(posedge sys_clk) disable iff (!arst_n) // [RULE1] [RULE6]
    pair_nonpos(mod_coef) && (delta_t_r >= 0)
    |=> mod_comp_r <= $past(mod_nom_code))
    else $error("modulation code rose under non-positive coefficients");
  a_pd_grow: assert property (@(posedge sys_clk) disable iff (!arst_n) // [RULE1] [RULE6]
    pair_nonneg(pd_coef) && (delta_t_r >= 0)
    |=> pd_comp_r >= $past(pd_nom_code))
    else $error("photodiode code fell under non-negative coefficients");
  a_pd_shrink: assert property (@(posedge sys_clk) disable iff (!arst_n) // [RULE1] [RULE6]
    pair_nonpos(pd_coef) && (delta_t_r >= 0)
    |=> pd_comp_r <= $past(pd_nom_code))
    else $error("photodiode code rose under non-positive coefficients");

  // main scenarios
  c_ext_sel: cover property (@(posedge sys_clk) system_settings.ext_temp_en);
  c_neg_dt: cover property (@(posedge sys_clk) delta_t_r < 0);
  c_sat_hi: cover property (@(posedge sys_clk) bias_comp_r == {CW{1'b1}});
  c_sat_lo: cover property (@(posedge sys_clk) disable iff (!arst_n) (mod_nom_code != '0) ##1 (mod_comp_r == '0));
  c_apc_on: cover property (@(posedge sys_clk) disable iff (!arst_n) apc_en_r);
endmodule
`default_nettype wire

/* tb/tb.sv */
// self-checking bench for the temperature compensation datapath
`timescale 1ns/100ps
`default_nettype none
module tb;
  import ltcomp_pkg::*;
  typedef struct packed {
    logic [DT_W-1:0] dt;
    logic [CODE_W-1:0] b, m, p;
    logic apc;
  } ltcomp_exp_t;
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  ltcomp_sys_t sys_s = '0;
  logic [TEMP_W-1:0] t_die = '0;
  logic [CODE_W-1:0] nb = '0, nm = '0, np = '0, ob, om, op;
  ltcomp_coef_t cb = '0, cm = '0, cp = '0;
  logic apc_o;
  logic signed [DT_W-1:0] dt_o;
  logic chk_now = 1'b0;
  ltcomp_exp_t exp_q[$];
  int num_errors = 0;
  int n_tests = 0;
  always #20 sys_clk = ~sys_clk;
  ltcomp_top dut_u (.sys_clk(sys_clk), .arst_n(arst_n), .system_settings(sys_s), .t_die_adc(t_die),
    .bias_nom_code(nb), .mod_nom_code(nm), .pd_nom_code(np), .bias_coef(cb), .mod_coef(cm),
    .pd_coef(cp), .bias_comp_r(ob), .mod_comp_r(om), .pd_comp_r(op), .apc_en_r(apc_o), .delta_t_r(dt_o));
  // reference scaling of one code, floored and clamped
  function automatic logic [CODE_W-1:0] scale(logic [CODE_W-1:0] nom, ltcomp_coef_t c, longint dt);
    longint acc;
    acc = longint'(c.second_order_coef) * dt * dt;
    acc = acc + longint'(c.first_order_coef) * dt * (1 << (SHIFT_Q - SHIFT_L)) + (1 << SHIFT_Q);
    acc = (longint'(nom) * acc) >>> SHIFT_Q;
    if (acc > (1 << CODE_W) - 1) acc = (1 << CODE_W) - 1;
    if (acc < 0) acc = 0;
    return acc[CODE_W-1:0];
  endfunction
  task automatic check(string name, logic [15:0] seen, logic [15:0] expv);
    n_tests++;
    if (seen !== expv) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", name, expv, seen);
    end
  endtask
  task automatic conclude();
    if (num_errors == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // compares settled outputs with the oldest expectation
  always @(posedge sys_clk) begin : watch
    ltcomp_exp_t e;
    if (chk_now && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      check("delta_t", {5'h0, dt_o}, {5'h0, e.dt});
      check("bias", {6'h0, ob}, {6'h0, e.b});
      check("mod", {6'h0, om}, {6'h0, e.m});
      check("pd", {6'h0, op}, {6'h0, e.p});
      check("apc", {15'h0, apc_o}, {15'h0, e.apc});
    end
  end
  // random stimulus with a few corner vectors first
  initial begin
    longint dt;
    ltcomp_exp_t e;
    void'($urandom(32'h48e6));
    repeat (20) @(posedge sys_clk);
    #1 arst_n = 1'b1;
    for (int i = 0; i < 120; i++) begin
      @(posedge sys_clk);
      #1 chk_now = 1'b0;
      {sys_s, t_die} = 32'($urandom);
      {nb, nm, np} = 30'($urandom);
      {cb, cm} = 32'($urandom);
      cp = 16'($urandom);
      if (i < 2) begin
        t_die = i ? 10'h000 : 10'h3ff;
        sys_s.t_nom = i ? 10'h3ff : 10'h000;
        sys_s.ext_temp_en = 1'b0;
        cb = 16'h7f7f;
        cm = 16'h8080;
      end
      if (i == 2) begin
        sys_s.ext_temp_en = 1'b0;
        t_die = sys_s.t_nom; // zero deviation
        nb = 10'h2a5;
        cb = '0; // zero pair passes the nominal code
        np = '0; // zero nominal code stays zero
      end
      if (i == 3) begin
        {nm, np} = {nb, nb}; // one input set on all channels
        {cm, cp} = {cb, cb};
      end
      dt = longint'(sys_s.ext_temp_en ? sys_s.t_ext : t_die) - longint'(sys_s.t_nom);
      e.dt = dt[DT_W-1:0];
      e.b = scale(nb, cb, dt);
      e.m = scale(nm, cm, dt);
      e.p = scale(np, cp, dt);
      e.apc = sys_s.apc_en;
      repeat (3) @(posedge sys_clk);
      #1 exp_q.push_back(e);
      chk_now = 1'b1;
    end
    @(posedge sys_clk);
    #1 chk_now = 1'b0;
    arst_n = 1'b0;
    #1 check("reset", {5'h0, ob, apc_o}, 16'h0000);
    check("reset_mod", {6'h0, om}, 16'h0000);
    check("reset_pd", {6'h0, op}, 16'h0000);
    check("reset_dt", {5'h0, dt_o}, 16'h0000);
    if (exp_q.size() != 0) num_errors++;
    conclude();
  end
endmodule
`default_nettype wire
